// ---- dmrd_cmd_hold.sv ----
// Holds read and write commands for the programmed added delay.
// Assumes one command per clock at most, decoded by the caller.
`timescale 1ns/1ns
module dmrd_cmd_hold
  import dmrd_pkg::*;
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset_n,
  // Commands from the pins and the added delay
  input  wire logic       i_read,
  input  wire logic       i_write,
  input  wire logic [4:0] i_added_delay,
  // Commands issued inside
  output logic            o_read_issue,
  output logic            o_write_issue
);

  typedef struct packed {
    logic [DMRD_HOLD_DEPTH-1:0] rd_line;
    logic [DMRD_HOLD_DEPTH-1:0] wr_line;
  } dmrd_hold_type;

  dmrd_hold_type state_reg;
  dmrd_hold_type state_next;
  logic [3:0]    tap;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next         = state_reg;
    state_next.rd_line = {state_reg.rd_line[DMRD_HOLD_DEPTH-2:0], i_read};
    state_next.wr_line = {state_reg.wr_line[DMRD_HOLD_DEPTH-2:0], i_write};
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Tap the line at the added delay; zero passes straight through
  assign tap           = 4'(i_added_delay - 5'h01);
  assign o_read_issue  = (i_added_delay == 5'h00) ? i_read : state_reg.rd_line[tap];
  assign o_write_issue = (i_added_delay == 5'h00) ? i_write : state_reg.wr_line[tap];

endmodule : dmrd_cmd_hold

// ---- dmrd_ctrl_model.sv ----
// Controller model that drives mode-set, read and write commands.
// Assumes the device samples its pins on the rising edge of i_clk.
`timescale 1ns/1ns
module dmrd_ctrl_model (
  // Clock
  input  wire logic   i_clk,
  // Command pins
  output logic        o_cs_n,
  output logic        o_ras_n,
  output logic        o_cas_n,
  output logic        o_we_n,
  output logic [2:0]  o_bank_select,
  output logic [15:0] o_addr,
  output logic        o_die_termination_pin
);
  initial begin
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_bank_select = 3'h0;
    o_addr = 16'h0000;
    o_die_termination_pin = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // Command order: cs, ras, cas, we
  task automatic drive(input logic [3:0] cmd, input logic [2:0] bank, input logic [15:0] addr);
    @(posedge i_clk);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= cmd;
    o_bank_select <= bank;
    o_addr <= addr;
  endtask : drive
  // Deselect; released lines show the inverse value
  task automatic idle();
    @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_bank_select <= ~o_bank_select;
    o_addr <= ~o_addr;
  endtask : idle
  // All four pins low, bank picks the register
  task automatic mode_set(input logic [2:0] bank, input logic [15:0] addr);
    drive(4'h0, bank, (bank == 3'h3) ? (addr & 16'h0007) : addr);
    idle();
  endtask : mode_set
  // Termination request, changed on the current edge
  task automatic set_termination(input logic on);
    o_die_termination_pin <= on;
  endtask : set_termination
endmodule : dmrd_ctrl_model

// ---- dmrd_decode.sv ----
// Mode register decode for the second, third and fourth mode registers.
// Assumes pins are synchronous to i_clk and the read column latency comes from elsewhere.
`timescale 1ns/1ns

// Overview of operation
// - Hold read/write for added delay before issue
// - Read latency equals added plus read column
// - Write latency equals added plus write column
// - Write column latency field, whole cycles only
// - Output disable bit disconnects data and strobes
// - Bank code two writes third register
// - Bank code three writes fourth register
// - Pattern disabled ignores location bits
// - Location zero returns predefined pattern
// - Write termination selected by A9, A10
// - Write termination applies without nominal
// - Leveling uses nominal termination only
// - Partial retention range exposed for self-refresh
// - Hot bit doubles self-refresh rate
// - Bank code one writes second register
module dmrd_decode
  import dmrd_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Command pins
  input  wire logic        i_cs_n,
  input  wire logic        i_ras_n,
  input  wire logic        i_cas_n,
  input  wire logic        i_we_n,
  input  wire logic [2:0]  i_bank_select,
  input  wire logic [15:0] i_addr,
  input  wire logic        i_die_termination_pin,
  // Read column latency from the first mode register
  input  wire logic [4:0]  i_read_column_latency,
  // Latencies and issued commands
  output logic [4:0]       o_added_delay,
  output logic [5:0]       o_write_column_latency,
  output logic [5:0]       o_total_read_latency,
  output logic [5:0]       o_total_write_latency,
  output logic             o_read_issue,
  output logic             o_write_issue,
  // Output and termination control
  output logic             o_outputs_disabled,
  output logic             o_write_leveling,
  output logic [2:0]       o_termination_code,
  output logic             o_termination_is_write,
  // Refresh control
  output logic             o_hot_self_refresh_rate,
  output logic [2:0]       o_partial_array_retention,
  // Readback pattern
  output logic             o_readback_active,
  output logic [7:0]       o_readback_pattern
);

  typedef struct packed {
    logic [1:0] al_code;
    logic       level_en;
    logic       out_dis;
    logic [2:0] rtt_nom;
    logic [2:0] cwl_code;
    logic       hot_self_refresh_rate;
    logic [1:0] rtt_wr;
    logic [2:0] partial_array_retention;
    logic       mpr_en;
    logic [1:0] mpr_loc;
    logic [5:0] rd_lat;
    logic [5:0] wr_lat;
    logic [4:0] wr_win;
    logic [2:0] term;
    logic       term_wr;
  } dmrd_state_type;

  dmrd_state_type state_reg;
  dmrd_state_type state_next;
  logic           mode_set;
  logic           cmd_read;
  logic           cmd_write;
  logic [4:0]     added;
  logic [5:0]     write_column_latency;

  function automatic logic is_cmd(input logic cs_n, input logic ras_n, input logic cas_n, input logic we_n,
                                  input logic [2:0] code);
    is_cmd = !cs_n && ({ras_n, cas_n, we_n} == code);
  endfunction : is_cmd

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  assign mode_set  = is_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n, 3'h0);
  assign cmd_read  = is_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n, 3'h5);
  assign cmd_write = is_cmd(i_cs_n, i_ras_n, i_cas_n, i_we_n, 3'h4);

  // Added delay from code and read column latency
  always_comb begin
    unique case (state_reg.al_code)
      DMRD_AL_CL1: added = i_read_column_latency - 5'h01;
      DMRD_AL_CL2: added = i_read_column_latency - 5'h02;
      default:     added = 5'h00;
    endcase
  end

  assign write_column_latency = DMRD_CWL_BASE + {3'h0, state_reg.cwl_code};

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    if (mode_set && i_bank_select == DMRD_BANK_SECOND) begin
      state_next.al_code  = i_addr[DMRD_AL_LSB +: 2];
      state_next.level_en = i_addr[DMRD_LEVEL_BIT];
      state_next.out_dis  = i_addr[DMRD_QOFF_BIT];
      state_next.rtt_nom  = {i_addr[DMRD_NOM_BIT2], i_addr[DMRD_NOM_BIT1], i_addr[DMRD_NOM_BIT0]};
    end
    if (mode_set && i_bank_select == DMRD_BANK_THIRD) begin
      state_next.partial_array_retention     = i_addr[DMRD_PARTIAL_ARRAY_RETENTION_LSB +: 3];
      state_next.cwl_code = i_addr[DMRD_CWL_LSB +: 3];
      state_next.hot_self_refresh_rate      = i_addr[DMRD_SRT_BIT];
      state_next.rtt_wr   = i_addr[DMRD_RTTWR_LSB +: 2];
    end
    if (mode_set && i_bank_select == DMRD_BANK_FOURTH) begin
      state_next.mpr_en  = i_addr[DMRD_MPR_BIT];
      state_next.mpr_loc = i_addr[DMRD_LOC_LSB +: 2];
    end
    state_next.rd_lat = {1'b0, added} + {1'b0, i_read_column_latency};
    state_next.wr_lat = {1'b0, added} + write_column_latency;
    // Write window from internal write through the burst
    if (o_write_issue) begin
      state_next.wr_win = 5'(write_column_latency) + DMRD_BURST_CLOCKS;
    end else if (state_reg.wr_win != 5'h00) begin
      state_next.wr_win = state_reg.wr_win - 5'h01;
    end
    // Termination choice
    state_next.term_wr = 1'b0;
    state_next.term    = DMRD_RESET_3;
    if (i_die_termination_pin) begin
      if (state_reg.wr_win != 5'h00 && state_reg.rtt_wr != DMRD_RESET_2
          && !state_reg.level_en) begin
        state_next.term_wr = 1'b1;
        state_next.term    = {1'b0, state_reg.rtt_wr};
      end else begin
        state_next.term = state_reg.rtt_nom;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  dmrd_cmd_hold u_hold (
    .i_clk         (i_clk),
    .i_reset_n     (i_reset_n),
    .i_read        (cmd_read),
    .i_write       (cmd_write),
    .i_added_delay (added),
    .o_read_issue  (o_read_issue),
    .o_write_issue (o_write_issue)
  );

  assign o_added_delay             = added;
  assign o_write_column_latency    = write_column_latency;
  assign o_total_read_latency      = state_reg.rd_lat;
  assign o_total_write_latency     = state_reg.wr_lat;
  assign o_outputs_disabled        = state_reg.out_dis;
  assign o_write_leveling          = state_reg.level_en;
  assign o_termination_code        = state_reg.term;
  assign o_termination_is_write    = state_reg.term_wr;
  assign o_hot_self_refresh_rate   = state_reg.hot_self_refresh_rate;
  assign o_partial_array_retention = state_reg.partial_array_retention;
  assign o_readback_active = state_reg.mpr_en && state_reg.mpr_loc == DMRD_LOC_PATTERN;
  assign o_readback_pattern = o_readback_active ? DMRD_SYNC_PATTERN : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_read_at_delay3;
    cmd_read && added == 5'h03 && $stable(added);
  endsequence
  sequence s_third_set;
    mode_set && i_bank_select == DMRD_BANK_THIRD;
  endsequence
  sequence s_fourth_set;
    mode_set && i_bank_select == DMRD_BANK_FOURTH;
  endsequence

  a_added_delay_hold: assert property (s_read_at_delay3 ##1 $stable(added) [*3] |-> o_read_issue)
    else $error("read not issued after added delay");
  a_read_lat_sum: assert property ($past(i_reset_n) |->
      o_total_read_latency == 6'($past(added) + $past(i_read_column_latency)))
    else $error("read latency sum wrong");
  a_write_lat_sum: assert property ($past(i_reset_n) |->
      o_total_write_latency == 6'($past(added)) + $past(write_column_latency))
    else $error("write latency sum wrong");
  a_cwl_field: assert property (s_third_set |=>
      o_write_column_latency == DMRD_CWL_BASE + 6'($past(i_addr[5:3])))
    else $error("write column latency field wrong");
  a_output_disable: assert property (mode_set && i_bank_select == DMRD_BANK_SECOND |=>
      o_outputs_disabled == $past(i_addr[12]))
    else $error("output disable not taken");
  a_hot_rate_set: assert property (s_third_set |=> o_hot_self_refresh_rate == $past(i_addr[7]))
    else $error("hot rate bit not taken");
  a_fourth_set: assert property (s_fourth_set |=>
      o_readback_active == ($past(i_addr[2]) && $past(i_addr[1:0]) == 2'h0))
    else $error("readback control not taken");
  a_pattern_ignore: assert property (s_fourth_set ##0 !i_addr[DMRD_MPR_BIT] |=>
      !o_readback_active && o_readback_pattern == 8'h00)
    else $error("location honoured while pattern disabled");
  a_leveling_nominal: assert property (state_reg.level_en && i_die_termination_pin |=>
      !o_termination_is_write && o_termination_code == $past(state_reg.rtt_nom))
    else $error("write termination used during leveling");
  a_write_term: assert property (o_write_issue && !state_reg.level_en && state_reg.rtt_wr != 2'h0
      ##1 i_die_termination_pin |=> o_termination_is_write)
    else $error("write termination not applied");

endmodule : dmrd_decode

// ---- dmrd_pkg.sv ----
// Constants shared by the mode register decode block.
// Assumes command and address pins are already sampled on the device clock.
package dmrd_pkg;
  // Bank codes selecting each mode register
  localparam logic [2:0] DMRD_BANK_SECOND = 3'h1;
  localparam logic [2:0] DMRD_BANK_THIRD  = 3'h2;
  localparam logic [2:0] DMRD_BANK_FOURTH = 3'h3;
  // Second mode register fields
  localparam int DMRD_AL_LSB     = 3;
  localparam int DMRD_LEVEL_BIT  = 7;
  localparam int DMRD_QOFF_BIT   = 12;
  localparam int DMRD_NOM_BIT0   = 2;
  localparam int DMRD_NOM_BIT1   = 6;
  localparam int DMRD_NOM_BIT2   = 9;
  // Third mode register fields
  localparam int DMRD_PARTIAL_ARRAY_RETENTION_LSB   = 0;
  localparam int DMRD_CWL_LSB    = 3;
  localparam int DMRD_SRT_BIT    = 7;
  localparam int DMRD_RTTWR_LSB  = 9;
  // Fourth mode register fields
  localparam int DMRD_LOC_LSB    = 0;
  localparam int DMRD_MPR_BIT    = 2;
  // Added delay codes
  localparam logic [1:0] DMRD_AL_ZERO = 2'h0;
  localparam logic [1:0] DMRD_AL_CL1  = 2'h1;
  localparam logic [1:0] DMRD_AL_CL2  = 2'h2;
  // Write column latency of code zero
  localparam logic [5:0] DMRD_CWL_BASE = 6'h05;
  // Clocks of a data burst at the pins
  localparam logic [4:0] DMRD_BURST_CLOCKS = 5'h04;
  // Depth of the held command line
  localparam int DMRD_HOLD_DEPTH = 16;
  // Readback pattern location that carries the pattern
  localparam logic [1:0] DMRD_LOC_PATTERN = 2'h0;
  // Predefined read synchronisation pattern
  localparam logic [7:0] DMRD_SYNC_PATTERN = 8'h55;
  // Values after reset
  localparam logic [2:0] DMRD_RESET_3 = 3'h0;
  localparam logic [1:0] DMRD_RESET_2 = 2'h0;
endpackage : dmrd_pkg

// ---- tb.sv ----
// Self-checking bench for the mode register decode block.
// Assumes the controller model owns every command pin.
`timescale 1ns/1ns
module tb;
  import dmrd_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [4:0]  rcl = 5'h0b;
  logic        cs_n, ras_n, cas_n, we_n, die_termination_pin, rdi, wri, qoff, lvl, termw, hot, rba;
  logic [2:0]  bank, term, partial_array_retention;
  logic [15:0] addr;
  logic [4:0]  added;
  logic [5:0]  wcl, trl, twl;
  logic [7:0]  rbp, n;
  logic [2:0]  rb_loc [3] = '{3'h4, 3'h5, 3'h0};
  logic        rb_act [3] = '{1'b1, 1'b0, 1'b0};
  int          miscompares = 0;
  int          num_checks = 0;
  always #20 i_clk = ~i_clk;
  dmrd_ctrl_model ctl (.i_clk(i_clk), .o_cs_n(cs_n), .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n),
    .o_bank_select(bank), .o_addr(addr), .o_die_termination_pin(die_termination_pin));
  dmrd_decode dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_bank_select(bank), .i_addr(addr), .i_die_termination_pin(die_termination_pin),
    .i_read_column_latency(rcl), .o_added_delay(added), .o_write_column_latency(wcl),
    .o_total_read_latency(trl), .o_total_write_latency(twl), .o_read_issue(rdi), .o_write_issue(wri),
    .o_outputs_disabled(qoff), .o_write_leveling(lvl), .o_termination_code(term),
    .o_termination_is_write(termw), .o_hot_self_refresh_rate(hot), .o_partial_array_retention(partial_array_retention),
    .o_readback_active(rba), .o_readback_pattern(rbp));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic settle();
    repeat (2) @(posedge i_clk);
    #1;
  endtask : settle
  task automatic write_then_wait();
    ctl.drive(4'h4, 3'h0, 16'h0000);
    #1;
    check(wri, 8'h01);
    ctl.idle();
    settle();
  endtask : write_then_wait
  task automatic read_wait(input logic [7:0] exp);
    ctl.drive(4'h5, 3'h0, 16'h0000);
    ctl.idle();
    n = 8'h01;
    #1;
    while (rdi !== 1'b1 && n < 8'h14) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(n, exp);
  endtask : read_wait
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    check(wcl, 8'h05);
    check(qoff, 8'h00);
    check(hot, 8'h00);
    ctl.mode_set(3'h2, 16'h049d);
    ctl.mode_set(3'h1, 16'h1010);
    settle();
    check(wcl, 8'h08);
    check(hot, 8'h01);
    check(partial_array_retention, 8'h05);
    check(added, 8'h09);
    check(trl, 8'h14);
    check(twl, 8'h11);
    check(qoff, 8'h01);
    ctl.mode_set(3'h0, 16'h0000);
    settle();
    check(hot, 8'h01);
    // Read held for the added delay
    read_wait(8'h09);
    // Readback pattern: enabled, reserved location, disabled
    for (int k = 0; k < 3; k++) begin
      ctl.mode_set(3'h3, {13'h0000, rb_loc[k]});
      settle();
      check(rba, rb_act[k]);
      check(rbp, rb_act[k] ? DMRD_SYNC_PATTERN : 8'h00);
    end
    // Write termination with nominal off
    ctl.mode_set(3'h1, 16'h0000);
    ctl.set_termination(1'b1);
    write_then_wait();
    check(term, 8'h02);
    check(termw, 8'h01);
    // Leveling keeps nominal termination
    ctl.mode_set(3'h1, 16'h0084);
    repeat (16) @(posedge i_clk);
    write_then_wait();
    check(lvl, 8'h01);
    check(term, 8'h01);
    check(termw, 8'h00);
    // Added delay of read column latency minus one
    @(posedge i_clk);
    rcl <= 5'h04;
    ctl.mode_set(3'h1, 16'h0008);
    settle();
    check(added, 8'h03);
    check(trl, 8'h07);
    check(twl, 8'h0b);
    check(lvl, 8'h00);
    read_wait(8'h03);
    summarize();
  end
endmodule : tb
